// [hw/uart_line_modem_status.sv]
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_status
	import uart_lsr_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic serial_rx_line,
	input wire logic infrared_rx_line,
	input wire logic carrier_detect_in_n,
	input wire logic call_alert_in_n
);
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam logic [AW:0] FIFO_FULL = (AW + 1)'(FIFO_DEPTH);
	localparam logic [AW:0] CNT_ONE = (AW + 1)'(1);

	// APB decode
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	wire setup = psel & ~penable;
	wire done = psel & penable & pready_q;
	wire hit_lsr = paddr == LINE_STATUS_ADDR;
	wire hit_msr = paddr == MODEM_STATUS_ADDR;
	wire hit_cfg = paddr == LINE_CONFIG_ADDR;
	wire hit_div = paddr == BAUD_DIV_ADDR;
	wire hit_rbr = paddr == RX_BUFFER_ADDR;
	wire mapped = hit_lsr | hit_msr | hit_cfg | hit_div | hit_rbr;
	wire lsr_done = done & ~pwrite & hit_lsr;
	wire rbr_done = done & ~pwrite & hit_rbr;
	wire cfg_wr = done & pwrite & hit_cfg;
	wire div_wr = done & pwrite & hit_div;

	logic [CFG_WIDTH-1:0] cfg_q;
	logic [15:0] baud_div_q;
	wire fifo_en = cfg_q[CFG_FIFO_ENABLE];
	wire loopback = cfg_q[CFG_LOOPBACK];
	wire ir_sel = cfg_q[CFG_INFRARED];
	wire par_en = cfg_q[CFG_PARITY_ENABLE];
	wire [2:0] data_last = MIN_DATA_LAST + {1'b0, cfg_q[CFG_LEN_HI:CFG_LEN_LO]};
	// Switching FIFO mode discards queued data so the two modes never share stale state
	wire flush = cfg_wr & (pwdata[CFG_FIFO_ENABLE] != fifo_en);

	// Baud sampling tick, sixteen per bit
	logic [15:0] div_cnt_q;
	wire tick = div_cnt_q == 16'h0000;
	// A zero divisor runs at the full clock rate, like a divisor of one
	wire [15:0] div_reload = (baud_div_q == 16'h0000) ? 16'h0000 : baud_div_q - 16'h0001;

	// Receive line selection
	logic ir_low_q;
	wire line_now = loopback | (ir_sel ? infrared_rx_line : serial_rx_line);
	// Infrared: any low pulse in the half bit before the sample point makes the bit a zero
	wire bit_val = loopback | (ir_sel ? ~(ir_low_q | ~infrared_rx_line) : serial_rx_line);

	rx_state_type state_q;
	rx_state_type state_d;
	logic [3:0] sub_q;
	logic [2:0] idx_q;
	logic [7:0] shift_q;
	logic par_q;
	logic par_q_err_q;
	logic all_low_q;
	wire sample = tick & (sub_q == SAMPLE_LAST);
	wire mid = tick & (sub_q == SAMPLE_MID);
	wire par_bad = par_en & ((par_q ^ bit_val) ^ ~cfg_q[CFG_EVEN_PARITY]);
	wire stop_ok = bit_val;
	wire frame_low = all_low_q & ~bit_val;

	// Completed character
	logic push;
	rx_entry_type push_entry;
	always_comb begin
		push = state_q == RX_STOP && sample;
		push_entry.data = frame_low ? 8'h00 : shift_q;
		push_entry.brk = frame_low;
		push_entry.fe = ~stop_ok;
		push_entry.pe = frame_low | par_q_err_q;
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			RX_IDLE: begin
				if (!line_now) begin
					state_d = RX_START;
				end
			end
			RX_START: begin
				if (mid) begin
					state_d = bit_val ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (sample && idx_q == data_last) begin
					state_d = par_en ? RX_PARITY : RX_STOP;
				end
			end
			RX_PARITY: begin
				if (sample) begin
					state_d = RX_STOP;
				end
			end
			RX_STOP: begin
				if (sample) begin
					if (stop_ok) begin
						state_d = RX_IDLE;
					end else if (frame_low) begin
						state_d = RX_BREAK_WAIT;
					end else begin
						state_d = RX_DATA;
					end
				end
			end
			RX_BREAK_WAIT: begin
				// One break gives one character: nothing restarts until the line rises
				if (line_now) begin
					state_d = RX_IDLE;
				end
			end
			default: state_d = RX_IDLE;
		endcase
	end

	wire fresh_frame = state_d == RX_DATA && state_q != RX_DATA;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt_q <= 16'h0000;
			state_q <= RX_IDLE;
		end else begin
			div_cnt_q <= tick ? div_reload : div_cnt_q - 16'h0001;
			state_q <= state_d;
		end
	end

	// Bit window counter and infrared low-pulse latch
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ir_low_q <= 1'b0;
			sub_q <= 4'h0;
		end else begin
			if (state_q == RX_IDLE || mid || sample) begin
				ir_low_q <= 1'b0;
			end else if (!infrared_rx_line) begin
				ir_low_q <= 1'b1;
			end
			if (state_q == RX_IDLE || (mid && state_q == RX_START)) begin
				sub_q <= 4'h0;
			end else if (tick) begin
				sub_q <= sub_q + 4'h1;
			end
		end
	end

	// Character assembly; a fresh frame includes resync from a bad stop bit
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			idx_q <= 3'h0;
			shift_q <= 8'h00;
			par_q <= 1'b0;
			all_low_q <= 1'b0;
		end else if (fresh_frame) begin
			idx_q <= 3'h0;
			par_q <= 1'b0;
			all_low_q <= 1'b1;
			shift_q <= 8'h00;
		end else if (sample && state_q == RX_DATA) begin
			shift_q[idx_q] <= bit_val;
			idx_q <= idx_q + 3'h1;
			par_q <= par_q ^ bit_val;
			all_low_q <= all_low_q & ~bit_val;
		end else if (sample && state_q == RX_PARITY) begin
			all_low_q <= all_low_q & ~bit_val;
		end
	end

	// Cleared at every frame start so a resynchronised character never inherits a verdict
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			par_q_err_q <= 1'b0;
		end else if (fresh_frame) begin
			par_q_err_q <= 1'b0;
		end else if (sample && state_q == RX_PARITY) begin
			par_q_err_q <= par_bad;
		end
	end

	// Receive FIFO, depth one in non-FIFO mode
	rx_entry_type mem [FIFO_DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] cnt_q;
	logic [AW:0] err_cnt_q;
	wire empty = cnt_q == '0;
	wire full = cnt_q == FIFO_FULL;
	wire pop = rbr_done & ~empty;
	wire do_push = push & (fifo_en ? ~full : 1'b1);
	wire push_err = push_entry.brk | push_entry.fe | push_entry.pe;
	rx_entry_type top_entry;
	rx_entry_type next_entry;
	assign top_entry = mem[rd_ptr_q];
	assign next_entry = mem[rd_ptr_q + AW'(1)];
	wire top_err = top_entry.brk | top_entry.fe | top_entry.pe;
	wire overrun_set = push & (fifo_en ? full : (~empty & ~pop));
	// A character becomes the top entry: in FIFO mode its marks show only now
	wire reveal_push = fifo_en ? do_push & (empty | (pop & cnt_q == CNT_ONE)) : push;
	wire reveal_next = fifo_en & pop & (cnt_q > CNT_ONE);
	wire show_brk = (reveal_push & push_entry.brk) | (reveal_next & next_entry.brk);
	wire show_fe = (reveal_push & push_entry.fe) | (reveal_next & next_entry.fe);
	wire show_pe = (reveal_push & push_entry.pe) | (reveal_next & next_entry.pe);
	wire [AW:0] err_inc = (AW + 1)'(fifo_en & do_push & push_err);
	wire [AW:0] err_dec = (AW + 1)'(fifo_en & pop & top_err);
	wire [AW:0] cnt_inc = (AW + 1)'(do_push);
	wire [AW:0] cnt_dec = (AW + 1)'(pop);

	// Non-FIFO mode overwrites the entry at the read pointer, so no pointer moves
	always_ff @(posedge sys_clk) begin
		if (do_push) begin
			mem[fifo_en ? wr_ptr_q : rd_ptr_q] <= push_entry;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
			err_cnt_q <= '0;
		end else if (flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q <= '0;
			err_cnt_q <= '0;
		end else if (fifo_en) begin
			wr_ptr_q <= wr_ptr_q + AW'(do_push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			cnt_q <= cnt_q + cnt_inc - cnt_dec;
			err_cnt_q <= err_cnt_q + err_inc - err_dec;
		end else begin
			cnt_q <= push ? CNT_ONE : (pop ? '0 : cnt_q);
		end
	end

	// Sticky line status flags; an event in the clearing cycle wins
	logic brk_q;
	logic fe_q;
	logic pe_q;
	logic oe_q;
	wire clr_brk = lsr_done & prdata_q[LSR_BREAK];
	wire clr_fe = lsr_done & prdata_q[LSR_FRAMING];
	wire clr_pe = lsr_done & prdata_q[LSR_PARITY];
	wire clr_oe = lsr_done & prdata_q[LSR_OVERRUN];

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			brk_q <= 1'b0;
			fe_q <= 1'b0;
			pe_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			brk_q <= show_brk | (brk_q & ~clr_brk);
			fe_q <= show_fe | (fe_q & ~clr_fe);
			pe_q <= show_pe | (pe_q & ~clr_pe);
			oe_q <= overrun_set | (oe_q & ~clr_oe);
		end
	end

	// Modem inputs, two-stage synchronisers
	logic [1:0] dcd_sync_q;
	logic [1:0] ri_sync_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dcd_sync_q <= 2'b11;
			ri_sync_q <= 2'b11;
		end else begin
			dcd_sync_q <= {dcd_sync_q[0], carrier_detect_in_n};
			ri_sync_q <= {ri_sync_q[0], call_alert_in_n};
		end
	end
	wire carrier_flag = loopback ? cfg_q[CFG_AUX_OUT_TWO] : ~dcd_sync_q[1];
	wire call_alert_flag = loopback ? cfg_q[CFG_AUX_OUT_ONE] : ~ri_sync_q[1];

	// Read data
	logic [31:0] lsr_val;
	logic [31:0] msr_val;
	always_comb begin
		lsr_val = 32'h00000000;
		lsr_val[LSR_DATA_READY] = ~empty;
		lsr_val[LSR_OVERRUN] = oe_q;
		lsr_val[LSR_PARITY] = pe_q;
		lsr_val[LSR_FRAMING] = fe_q;
		lsr_val[LSR_BREAK] = brk_q;
		lsr_val[LSR_FIFO_ERROR] = fifo_en & (err_cnt_q != '0);
		msr_val = 32'h00000000;
		msr_val[MSR_CARRIER] = carrier_flag;
		msr_val[MSR_CALL_ALERT] = call_alert_flag;
	end
	wire [31:0] rd_mux = hit_lsr ? lsr_val :
		hit_msr ? msr_val :
		hit_cfg ? {{(32 - CFG_WIDTH){1'b0}}, cfg_q} :
		hit_div ? {16'h0000, baud_div_q} :
		hit_rbr ? {24'h000000, top_entry.data & {8{~empty}}} : 32'h00000000;

	// One wait-free access: pready rises in the first access cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~mapped;
			if (setup && !pwrite) begin
				prdata_q <= rd_mux;
			end
		end
	end

	// Control registers change only at the completing edge of a write
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= CFG_RESET;
			baud_div_q <= BAUD_DIV_RESET;
		end else begin
			if (cfg_wr) begin
				cfg_q <= pwdata[CFG_WIDTH-1:0];
			end
			if (div_wr) begin
				baud_div_q <= pwdata[15:0];
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

endmodule
`default_nettype wire

// [hw/uart_lsr_pkg.sv]
package uart_lsr_pkg;

	// Register byte addresses
	localparam logic [31:0] LINE_STATUS_ADDR = 32'h50001114;
	localparam logic [31:0] MODEM_STATUS_ADDR = 32'h50001118;
	localparam logic [31:0] LINE_CONFIG_ADDR = 32'h50001140;
	localparam logic [31:0] BAUD_DIV_ADDR = 32'h50001144;
	localparam logic [31:0] RX_BUFFER_ADDR = 32'h50001148;

	// line_status_reg fields
	localparam int LSR_DATA_READY = 0;
	localparam int LSR_OVERRUN = 1;
	localparam int LSR_PARITY = 2;
	localparam int LSR_FRAMING = 3;
	localparam int LSR_BREAK = 4;
	localparam int LSR_FIFO_ERROR = 7;

	// modem_status fields
	localparam int MSR_CALL_ALERT = 6;
	localparam int MSR_CARRIER = 7;

	// line_config fields (holds line, fifo and modem control bits)
	localparam int CFG_LEN_LO = 0;
	localparam int CFG_LEN_HI = 1;
	localparam int CFG_PARITY_ENABLE = 3;
	localparam int CFG_EVEN_PARITY = 4;
	localparam int CFG_FIFO_ENABLE = 8;
	localparam int CFG_LOOPBACK = 9;
	localparam int CFG_AUX_OUT_ONE = 10;
	localparam int CFG_AUX_OUT_TWO = 11;
	localparam int CFG_INFRARED = 12;
	localparam int CFG_WIDTH = 13;

	localparam logic [12:0] CFG_RESET = 13'h0000;
	localparam logic [15:0] BAUD_DIV_RESET = 16'h0001;

	// Receiver oversampling
	localparam logic [3:0] SAMPLE_MID = 4'h7;
	localparam logic [3:0] SAMPLE_LAST = 4'hf;
	localparam logic [2:0] MIN_DATA_LAST = 3'h4;

	typedef struct packed {
		logic brk;
		logic fe;
		logic pe;
		logic [7:0] data;
	} rx_entry_type;

	typedef enum logic [5:0] {
		RX_IDLE = 6'b000001,
		RX_START = 6'b000010,
		RX_DATA = 6'b000100,
		RX_PARITY = 6'b001000,
		RX_STOP = 6'b010000,
		RX_BREAK_WAIT = 6'b100000
	} rx_state_type;

endpackage

// [verif/uart_status_props.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_status_props
	import uart_lsr_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic serial_rx_line,
	input wire logic infrared_rx_line,
	input wire logic carrier_detect_in_n,
	input wire logic call_alert_in_n
);
	logic [12:0] cfg_q;
	wire acc = psel && penable && pready;
	wire mapped = paddr == LINE_STATUS_ADDR || paddr == MODEM_STATUS_ADDR || paddr == LINE_CONFIG_ADDR
		|| paddr == BAUD_DIV_ADDR || paddr == RX_BUFFER_ADDR;
	wire modem_rd = acc && !pwrite && paddr == MODEM_STATUS_ADDR;
	wire line_rd = acc && !pwrite && paddr == LINE_STATUS_ADDR;
	// Shadow of the config word so loopback reads can be judged from the bus alone
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= CFG_RESET;
		end else if (acc && pwrite && paddr == LINE_CONFIG_ADDR) begin
			cfg_q <= pwdata[12:0];
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
	a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_err_unmapped: assert property (psel && !penable && !mapped |=> pslverr) else $error("unmapped not refused");
	a_err_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr) else $error("mapped refused");
	a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
	a_status_upper_zero: assert property (line_rd |-> prdata[31:8] == 24'h0) else $error("status upper bits set");
	a_loop_carrier: assert property (modem_rd && cfg_q[9] |-> prdata[7] == cfg_q[11]) else $error("loop carrier");
	a_loop_call: assert property (modem_rd && cfg_q[9] |-> prdata[6] == cfg_q[10]) else $error("loop call alert");
	a_carrier_in: assert property (modem_rd && !cfg_q[9] |-> prdata[7] != $past(carrier_detect_in_n, 3))
		else $error("carrier flag not inverse of input");
	a_call_alert_in: assert property (modem_rd && !cfg_q[9] |-> prdata[6] != $past(call_alert_in_n, 3))
		else $error("call alert flag not inverse of input");
	c_refused: cover property (pslverr);
	c_infrared_low: cover property (cfg_q[12] && !infrared_rx_line);
	c_serial_low: cover property (!serial_rx_line);
	c_loop_read: cover property (modem_rd && cfg_q[9]);
	c_break_read: cover property (line_rd && prdata[4]);
endmodule
`default_nettype wire

// [verif/modem_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
module modem_line_model #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic sys_clk,
	output logic serial_rx_line,
	output logic infrared_rx_line,
	output logic carrier_detect_in_n,
	output logic call_alert_in_n
);
	// Line rests high between frames, modem lines start deasserted
	initial begin
		serial_rx_line = 1'b1;
		infrared_rx_line = 1'b1;
		carrier_detect_in_n = 1'b1;
		call_alert_in_n = 1'b1;
	end
	task automatic hold(input logic level, input int bits);
		@(posedge sys_clk);
		serial_rx_line <= level;
		repeat (bits * BIT_CYCLES - 1) @(posedge sys_clk);
	endtask
	task automatic ir_hold(input logic level, input int bits);
		@(posedge sys_clk);
		infrared_rx_line <= level;
		repeat (bits * BIT_CYCLES - 1) @(posedge sys_clk);
	endtask
	// Parity below zero means no parity bit; a zero stop makes a framing fault
	task automatic send(input logic [7:0] data, input int parity, input logic stop);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) hold(data[i], 1);
		if (parity >= 0) hold(parity[0], 1);
		hold(stop, 1);
		hold(1'b1, 1);
	endtask
	task automatic modem(input logic cd, input logic ca);
		@(posedge sys_clk);
		carrier_detect_in_n <= cd;
		call_alert_in_n <= ca;
		repeat (4) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// [verif/uart_line_modem_status_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_line_modem_status_bench;
	import uart_lsr_pkg::*;
	logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic serial_rx_line, infrared_rx_line, carrier_detect_in_n, call_alert_in_n;
	int fail_count = 0;
	int check_count = 0;
	always #5 sys_clk = ~sys_clk;
	uart_line_modem_status #(.FIFO_DEPTH(2)) uut(.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_rx_line, .infrared_rx_line, .carrier_detect_in_n, .call_alert_in_n);
	modem_line_model partner(.sys_clk, .serial_rx_line, .infrared_rx_line, .carrier_detect_in_n, .call_alert_in_n);
	task automatic test_done();
		$display("Checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// No local limit: a slave that never answers is ended by the watchdog as a failure
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input string what, input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	task automatic cfg(input logic [12:0] v);
		apb(1'b1, LINE_CONFIG_ADDR, {19'h0, v});
	endtask
	task automatic t_reset();
		rc("line status", LINE_STATUS_ADDR, 32'h0);
		rc("modem status", MODEM_STATUS_ADDR, 32'h0);
		rc("config reset", LINE_CONFIG_ADDR, {19'h0, CFG_RESET});
		rc("baud reset", BAUD_DIV_ADDR, {16'h0, BAUD_DIV_RESET});
		apb(1'b1, BAUD_DIV_ADDR, 32'h2);
		rc("baud divisor", BAUD_DIV_ADDR, 32'h2);
		apb(1'b1, BAUD_DIV_ADDR, {16'h0, BAUD_DIV_RESET});
		apb(1'b0, 32'h50001150, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("reset test done");
	endtask
	task automatic t_plain();
		cfg(13'h003);
		partner.send(8'ha5, -1, 1'b1);
		rc("ready", LINE_STATUS_ADDR, 32'h01);
		rc("buffer", RX_BUFFER_ADDR, 32'ha5);
		rc("ready cleared", LINE_STATUS_ADDR, 32'h0);
		partner.send(8'h11, -1, 1'b1);
		partner.send(8'h22, -1, 1'b1);
		rc("overrun", LINE_STATUS_ADDR, 32'h03);
		rc("overrun cleared", LINE_STATUS_ADDR, 32'h01);
		rc("overwritten", RX_BUFFER_ADDR, 32'h22);
		// Five data bits: data bit 5 of the sent byte lands in the stop slot
		cfg(13'h000);
		partner.send(8'hf5, -1, 1'b1);
		rc("five bit status", LINE_STATUS_ADDR, 32'h01);
		rc("five bit char", RX_BUFFER_ADDR, 32'h15);
		$display("plain test done");
	endtask
	task automatic t_errors();
		cfg(13'h01b);
		partner.send(8'h01, 0, 1'b1);
		rc("parity", LINE_STATUS_ADDR, 32'h05);
		rc("parity cleared", LINE_STATUS_ADDR, 32'h01);
		partner.send(8'h03, 0, 1'b1);
		rc("good parity", LINE_STATUS_ADDR, 32'h03);
		rc("buffer", RX_BUFFER_ADDR, 32'h03);
		cfg(13'h00b);
		partner.send(8'h01, 0, 1'b1);
		rc("odd parity", LINE_STATUS_ADDR, 32'h01);
		rc("odd buffer", RX_BUFFER_ADDR, 32'h01);
		cfg(13'h003);
		partner.send(8'h55, -1, 1'b0);
		rc("framing", LINE_STATUS_ADDR, 32'h09);
		// Bad stop slot is the next start, so an all-ones char follows
		repeat (160) @(posedge sys_clk);
		rc("resync status", LINE_STATUS_ADDR, 32'h03);
		rc("resync char", RX_BUFFER_ADDR, 32'hff);
		$display("error test done");
	endtask
	task automatic t_break();
		cfg(13'h01b);
		partner.hold(1'b0, 13);
		rc("break", LINE_STATUS_ADDR, 32'h1d);
		rc("break cleared", LINE_STATUS_ADDR, 32'h01);
		partner.hold(1'b1, 2);
		rc("one char", LINE_STATUS_ADDR, 32'h01);
		rc("zero char", RX_BUFFER_ADDR, 32'h0);
		rc("empty", LINE_STATUS_ADDR, 32'h0);
		// Infrared selected: the serial line stays idle, so only the infrared input can break
		cfg(13'h1003);
		partner.ir_hold(1'b0, 11);
		partner.ir_hold(1'b1, 2);
		rc("infrared break", LINE_STATUS_ADDR, 32'h1d);
		rc("infrared zero", RX_BUFFER_ADDR, 32'h0);
		$display("break test done");
	endtask
	task automatic t_fifo();
		cfg(13'h11b);
		partner.send(8'h3c, 0, 1'b1);
		partner.hold(1'b0, 13);
		partner.hold(1'b1, 2);
		rc("hidden mark", LINE_STATUS_ADDR, 32'h81);
		rc("first", RX_BUFFER_ADDR, 32'h3c);
		rc("mark at top", LINE_STATUS_ADDR, 32'h9d);
		rc("zero char", RX_BUFFER_ADDR, 32'h0);
		rc("drained", LINE_STATUS_ADDR, 32'h0);
		partner.send(8'h11, 0, 1'b1);
		partner.send(8'h22, 0, 1'b1);
		partner.send(8'h33, 0, 1'b1);
		rc("full overrun", LINE_STATUS_ADDR, 32'h03);
		rc("kept first", RX_BUFFER_ADDR, 32'h11);
		rc("kept second", RX_BUFFER_ADDR, 32'h22);
		rc("empty", LINE_STATUS_ADDR, 32'h0);
		$display("fifo test done");
	endtask
	task automatic t_modem();
		logic [1:0] i;
		cfg(13'h003);
		for (int k = 0; k < 4; k++) begin
			i = k[1:0];
			partner.modem(i[0], i[1]);
			rc("modem lines", MODEM_STATUS_ADDR, {24'h0, ~i[0], ~i[1], 6'h0});
		end
		// Inputs asserted so a missed loopback shows ones
		partner.modem(1'b0, 1'b0);
		for (int k = 0; k < 4; k++) begin
			i = k[1:0];
			cfg(13'h203 | {1'b0, i, 10'h0});
			rc("loopback", MODEM_STATUS_ADDR, {24'h0, i[1], i[0], 6'h0});
		end
		$display("modem test done");
	endtask
	initial begin
		repeat (60000) @(posedge sys_clk);
		fail_count++;
		$display("Error watchdog expected finish seen timeout");
		test_done();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_plain();
		t_errors();
		t_break();
		t_fifo();
		t_modem();
		test_done();
	end
endmodule
bind uart_line_modem_status uart_status_props #(.FIFO_DEPTH(FIFO_DEPTH)) props(.sys_clk, .rstn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_rx_line, .infrared_rx_line, .carrier_detect_in_n,
	.call_alert_in_n);
`default_nettype wire
